// *** supply_watchdog_reset_supervisor.sv ***
// Reset supervisor combining supply, manual and watchdog reset sources
`timescale 1ns/100ps
`include "supervisor_regs.svh"

// Function
// R1: Low supply asserts reset, then hold time
// R2: Manual reset low forces reset asserted
// R3: Manual release keeps reset for hold time
// R4: Kick constant for deadline asserts reset
// R5: Counter cleared on reset and kick edges
// R6: Host leaves kick undriven to disable
// R7: Watchdog reset lasts full hold time
// R8: Hold expiry releases reset, restarts counter
// R9: Active-high output is inverse, push-pull
// R10: Open-drain drives low only when asserted
// R11: Counter held zero while reset asserted
// R12: Floating kick serviced at seven eighths
// R13: Bidirectional line tolerates external low
// R14: Times and variant options are parameters
// R15: Hold restarts while any source active
module supply_watchdog_reset_supervisor #(
	parameter logic [`CNT_W-1:0] HOLD_CYCLES = `HOLD_CYCLES_DEFAULT, // R14
	parameter logic [`CNT_W-1:0] DEADLINE_CYCLES = `DEADLINE_CYCLES_DEFAULT,
	parameter supervisor_pkg::out_style_t OUT_STYLE = supervisor_pkg::OUT_PUSH_PULL,
	parameter bit HAS_MANUAL = 1'b1,
	parameter bit HAS_WATCHDOG = 1'b1
) (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	// Reset sources
	input wire logic I_SUPPLY_LOW,
	input wire logic I_MANUAL_RESET_IN_N,
	input wire logic I_WATCHDOG_KICK_IN,
	input wire logic I_WATCHDOG_KICK_FLOAT,
	// Reset line, active-low, as three signals
	input wire logic I_RESET_LINE_N,
	output logic O_RESET_N,
	output logic O_RESET_N_OE,
	// Active-high reset output
	output logic O_RESET
);

	// Reset state and counters
	supervisor_pkg::sup_state_t state_reg;
	logic [`CNT_W-1:0] hold_cnt_reg;
	logic [`CNT_W-1:0] wd_cnt_reg;
	logic kick_prev_reg;

	// State flags
	logic in_run;
	logic in_hold;
	logic reset_active;

	// Reset sources
	logic supply_active;
	logic manual_active;
	logic ext_low;
	logic any_source;

	// Hold interval decode
	logic [`CNT_W-1:0] hold_last;
	logic hold_done;

	// Watchdog decode
	logic [`CNT_W-1:0] deadline_last;
	logic [`CNT_W+3:0] float_prod;
	logic [`CNT_W-1:0] float_limit;
	logic float_limit_hit;
	logic kick_edge;
	logic wd_expired;
	logic wd_active;
	logic wd_clear;

	// Output style flags
	logic style_push_pull;
	logic style_bidir;

	// State flags; reset is asserted in every state but run
	assign in_run = (state_reg == supervisor_pkg::ST_RUN);
	assign in_hold = (state_reg == supervisor_pkg::ST_HOLD);
	assign reset_active = !in_run;

	// Output style decode
	assign style_push_pull = (OUT_STYLE == supervisor_pkg::OUT_PUSH_PULL);
	assign style_bidir = (OUT_STYLE == supervisor_pkg::OUT_BIDIR);

	// Reset sources; the sensed wire counts only in the run state, including its first cycle while the output enable is still set
	assign supply_active = I_SUPPLY_LOW; // R1
	assign manual_active = HAS_MANUAL && !I_MANUAL_RESET_IN_N; // R2
	assign ext_low = style_bidir && !I_RESET_LINE_N && in_run; // R13
	assign any_source = supply_active || manual_active || ext_low; // R15

	// Last count of the release hold interval
	assign hold_last = HOLD_CYCLES - `CNT_W'(1'h1);
	assign hold_done = (hold_cnt_reg >= hold_last); // R8

	// Internal service point at seven eighths of the deadline, product kept wide
	assign float_prod = (`CNT_W+4)'(DEADLINE_CYCLES) * (`CNT_W+4)'(`FLOAT_NUM);
	assign float_limit = `CNT_W'(float_prod >> `FLOAT_SHIFT);
	assign float_limit_hit = I_WATCHDOG_KICK_FLOAT && (wd_cnt_reg >= float_limit); // R12

	// Watchdog expiry; a kick edge in the last cycle still counts as service
	assign deadline_last = DEADLINE_CYCLES - `CNT_W'(1'h1);
	assign kick_edge = (I_WATCHDOG_KICK_IN != kick_prev_reg); // R5
	assign wd_expired = (wd_cnt_reg >= deadline_last); // R4
	assign wd_active = HAS_WATCHDOG && in_run && !kick_edge && !float_limit_hit && wd_expired;
	assign wd_clear = reset_active || any_source || wd_active; // R11

	// Kick history for edge detection
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			kick_prev_reg <= 1'b0;
		end else begin
			kick_prev_reg <= I_WATCHDOG_KICK_IN;
		end
	end

	// Reset state sequence: assert while a source is active, hold, then run
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			state_reg <= supervisor_pkg::ST_ASSERT;
		end else begin
			case (state_reg)
				supervisor_pkg::ST_ASSERT: begin
					if (!any_source) begin
						state_reg <= supervisor_pkg::ST_HOLD; // R3
					end
				end
				supervisor_pkg::ST_HOLD: begin
					if (any_source) begin
						state_reg <= supervisor_pkg::ST_ASSERT; // R15
					end else if (hold_done) begin
						state_reg <= supervisor_pkg::ST_RUN; // R8
					end
				end
				supervisor_pkg::ST_RUN: begin
					if (any_source) begin
						state_reg <= supervisor_pkg::ST_ASSERT; // R1
					end else if (wd_active) begin
						state_reg <= supervisor_pkg::ST_HOLD; // R7
					end
				end
				default: begin
					state_reg <= supervisor_pkg::ST_ASSERT;
				end
			endcase
		end
	end

	// Release hold counter; runs only in hold, so a new source restarts it
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			hold_cnt_reg <= '0;
		end else if (!in_hold || any_source || hold_done) begin
			hold_cnt_reg <= '0; // R15
		end else begin
			hold_cnt_reg <= hold_cnt_reg + `CNT_W'(1'h1); // R7
		end
	end

	// Watchdog counter; held at zero for the whole time reset is asserted
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			wd_cnt_reg <= '0;
		end else if (wd_clear) begin
			wd_cnt_reg <= '0; // R11
		end else if (kick_edge || float_limit_hit) begin
			wd_cnt_reg <= '0; // R5
		end else begin
			wd_cnt_reg <= wd_cnt_reg + `CNT_W'(1'h1);
		end
	end

	// Active-high output, driven both ways in every style
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_RESET <= 1'b1;
		end else begin
			O_RESET <= reset_active; // R9
		end
	end

	// Active-low data; open-drain and bidirectional styles only ever pull low
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_RESET_N <= 1'b0;
		end else if (style_push_pull) begin
			O_RESET_N <= in_run;
		end else begin
			O_RESET_N <= 1'b0; // R10
		end
	end

	// Output enable; the released wire is left to the pullup and other drivers
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			O_RESET_N_OE <= 1'b1;
		end else if (style_push_pull) begin
			O_RESET_N_OE <= 1'b1;
		end else begin
			O_RESET_N_OE <= reset_active; // R13
		end
	end

endmodule

// *** supervisor_regs.svh ***
// Timing and width constants for the reset supervisor
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH
`define HOLD_CYCLES_DEFAULT 32'd40000
`define DEADLINE_CYCLES_DEFAULT 32'd252000
`define FLOAT_NUM 32'd7
`define FLOAT_SHIFT 3
`define CNT_W 32
`endif

// *** supervisor_pkg.sv ***
// Types shared by the reset supervisor
package supervisor_pkg;
	typedef enum logic [1:0] {
		OUT_PUSH_PULL = 2'b00,
		OUT_OPEN_DRAIN = 2'b01,
		OUT_BIDIR = 2'b10
	} out_style_t;
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_RUN = 2'b01,
		ST_ASSERT = 2'b10
	} sup_state_t;
endpackage

// *** cpu_model.sv ***
// Processor model that services the watchdog kick
`timescale 1ns/100ps
module cpu_model (
	// Clock and reset line
	input wire logic clk,
	input wire logic rst_in,
	// Kick enable and kick line
	input wire logic en,
	output logic kick
);
	int cnt = 0;
	initial kick = 1'b0;
	// Toggle the kick every fourth cycle while enabled and out of reset
	always @(posedge clk) begin
		cnt <= (rst_in || cnt == 3) ? 0 : cnt + 1;
		if (!rst_in && en && cnt == 3) kick <= #1 ~kick;
	end
endmodule

// *** supervisor_checker.sv ***
// Port assertions for the reset supervisor
`timescale 1ns/100ps
module supervisor_checker #(
	parameter logic [31:0] DEADLINE_CYCLES = 32'd20
) (
	// Watched ports
	input wire logic I_REF_CLK,
	input wire logic I_RESET,
	input wire logic I_SUPPLY_LOW,
	input wire logic I_MANUAL_RESET_IN_N,
	input wire logic I_WATCHDOG_KICK_IN,
	input wire logic I_WATCHDOG_KICK_FLOAT,
	input wire logic O_RESET_N,
	input wire logic O_RESET_N_OE,
	input wire logic O_RESET
);
	logic src, kick_q;
	logic [31:0] cnt;
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);
	assign src = I_SUPPLY_LOW | ~I_MANUAL_RESET_IN_N;
	// Cycles run without a kick edge
	always_ff @(posedge I_REF_CLK) begin
		kick_q <= I_WATCHDOG_KICK_IN;
		cnt <= (O_RESET || I_WATCHDOG_KICK_FLOAT || kick_q != I_WATCHDOG_KICK_IN) ? 32'h0 : cnt + 32'h1;
	end
	sequence quiet_hold;
		$fell(src) ##1 !src [*8];
	endsequence
	a_supply_asserts: assert property (I_SUPPLY_LOW |-> ##3 O_RESET) else $error("no reset on low supply");
	a_manual_asserts: assert property (!I_MANUAL_RESET_IN_N |-> ##3 O_RESET) else $error("no manual reset");
	a_hold_kept: assert property ($fell(src) |-> ##2 O_RESET [*8]) else $error("hold cut short");
	a_hold_ends: assert property (quiet_hold |-> ##[1:4] !O_RESET) else $error("hold too long");
	a_wd_held: assert property ($rose(O_RESET) |-> O_RESET [*8]) else $error("reset pulse short");
	a_inverse_out: assert property (O_RESET == !O_RESET_N) else $error("outputs not inverse");
	a_push_pull: assert property (O_RESET_N_OE) else $error("output not driven");
	a_wd_deadline: assert property (cnt <= DEADLINE_CYCLES + 32'd3) else $error("watchdog late");
	a_float_quiet: assert property ($rose(O_RESET) && I_WATCHDOG_KICK_FLOAT |-> $past(src, 2))
		else $error("reset with floating kick");
endmodule

// *** testbench.sv ***
// Self-checking bench for the reset supervisor
`timescale 1ns/100ps
module testbench;
	localparam int H = 8;
	localparam int D = 20;
	logic clk = 1'b0, rst = 1'b1, sup = 1'b0, mr = 1'b1, fl = 1'b0, en = 1'b1;
	logic kick, o_n, oe, o;
	int n_fail = 0, cmp_count = 0, seed = 39442, n;
	// Reference clock
	always #12.5 clk = ~clk;
	supply_watchdog_reset_supervisor #(.HOLD_CYCLES(32'd8), .DEADLINE_CYCLES(32'd20))
		u_supply_watchdog_reset_supervisor (.I_REF_CLK(clk), .I_RESET(rst), .I_SUPPLY_LOW(sup),
		.I_MANUAL_RESET_IN_N(mr), .I_WATCHDOG_KICK_IN(kick), .I_WATCHDOG_KICK_FLOAT(fl),
		.I_RESET_LINE_N(1'b1), .O_RESET_N(o_n), .O_RESET_N_OE(oe), .O_RESET(o));
	cpu_model u_cpu_model (.clk(clk), .rst_in(o), .en(en), .kick(kick));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %0d expected %0d", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Count cycles while the reset output keeps one level
	task span(input logic lv, output int c);
		c = 0;
		while (o === lv && c < 400) begin
			tick(1);
			c++;
		end
		if (c >= 400) begin
			n_fail++;
			end_sim;
		end
	endtask
	// Main sequence
	initial begin
		tick(16);
		rst = 1'b0;
		span(1'b1, n);
		for (int i = 0; i < 4; i++) begin
			if (i[0]) mr = 1'b0;
			else sup = 1'b1;
			tick(3 + ($random(seed) & 3));
			chk(o, 1'b1);
			sup = 1'b0;
			mr = 1'b1;
			span(1'b1, n);
			chk(n, H + 2);
			tick(5 + ($random(seed) & 7));
		end
		en = 1'b0;
		span(1'b0, n);
		chk(n > D - 6 && n <= D + 4, 1'b1);
		span(1'b1, n);
		chk(n, H);
		fl = 1'b1;
		tick(3 * D);
		chk(o, 1'b0);
		chk(oe & (o_n ^ o), 1'b1);
		sup = 1'b1;
		tick(3);
		chk(o, 1'b1);
		sup = 1'b0;
		span(1'b1, n);
		chk(n, H + 2);
		rst = 1'b1;
		tick(2);
		chk(o, 1'b1);
		rst = 1'b0;
		span(1'b1, n);
		chk(n, H + 2);
		end_sim;
	end
endmodule
bind supply_watchdog_reset_supervisor supervisor_checker #(.DEADLINE_CYCLES(DEADLINE_CYCLES))
	u_supervisor_checker (.*);
